// File: ispr_assertions.sv
// Port-level property checks for the pixel readout block
`timescale 1ns/1ps
module ispr_assertions #(
	parameter [31:0] FRAME_CYCLES = 32'h7D0
) (
	// Clock and reset
	input wire        MCLK,
	input wire        RESETN,
	// APB handshake
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PREADY,
	input wire        PSLVERR,
	// Control pins
	input wire        OUTPUT_DISABLE,
	input wire        STANDBY_N,
	input wire        BUS_ADDRESS_SELECT,
	// Pixel port
	input wire        PIXEL_SAMPLE_CLOCK,
	input wire [11:0] DOUT,
	input wire        FRAME_QUAL,
	input wire        LINE_QUAL,
	input wire        EXPO_STROBE,
	input wire        PIX_OUT_EN_N,
	input wire [7:0]  BUS_DEVICE_ID
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	// Row capture may gate on both qualifiers
	chk_line_in_frame: assert property (LINE_QUAL |-> FRAME_QUAL)
		else $error("line qualifier high outside frame");
	// Data bus returns to zero when a line ends inside a frame
	chk_dout_idle: assert property ($fell(LINE_QUAL) && FRAME_QUAL |-> DOUT == 12'h000)
		else $error("data not idle after line");
	// Pins released after the synchroniser lag
	chk_oe_release: assert property (OUTPUT_DISABLE [*4] |=> PIX_OUT_EN_N)
		else $error("pixel port still driven");
	chk_oe_drive: assert property (!OUTPUT_DISABLE [*4] |=> !PIX_OUT_EN_N)
		else $error("pixel port not driven");
	// Two-wire address follows the select pin
	chk_id_high: assert property (BUS_ADDRESS_SELECT [*4] |=> BUS_DEVICE_ID == 8'hBA)
		else $error("wrong address with select high");
	chk_id_low: assert property (!BUS_ADDRESS_SELECT [*4] |=> BUS_DEVICE_ID == 8'h90)
		else $error("wrong address with select low");
	// Standby silences clock and qualifiers
	chk_standby_quiet: assert property (!STANDBY_N [*4] |=>
		!FRAME_QUAL && !LINE_QUAL && !PIXEL_SAMPLE_CLOCK)
		else $error("activity during standby");
	// Exactly one wait state on every access
	chk_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
		else $error("apb answer out of time");
	// A frame opens with its first pixel on a rising pixel clock
	chk_frame_on_tick: assert property ($rose(FRAME_QUAL) |->
		PIXEL_SAMPLE_CLOCK && LINE_QUAL)
		else $error("frame start off the pixel tick");
	cover property ($rose(FRAME_QUAL));
	cover property ($rose(EXPO_STROBE));
	cover property (PSLVERR);
endmodule // ispr_assertions

bind ispr_readout ispr_assertions #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
	.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .OUTPUT_DISABLE(OUTPUT_DISABLE), .STANDBY_N(STANDBY_N),
	.BUS_ADDRESS_SELECT(BUS_ADDRESS_SELECT), .PIXEL_SAMPLE_CLOCK(PIXEL_SAMPLE_CLOCK),
	.DOUT(DOUT), .FRAME_QUAL(FRAME_QUAL), .LINE_QUAL(LINE_QUAL), .EXPO_STROBE(EXPO_STROBE),
	.PIX_OUT_EN_N(PIX_OUT_EN_N), .BUS_DEVICE_ID(BUS_DEVICE_ID)
);

// File: ispr_binner.v
// Synthetic pixel source with same-colour row and column binning
`timescale 1ns/1ps
module ispr_binner (
	// Coordinates of the first tap
	input  wire [11:0] row,
	input  wire [11:0] col,
	// Bin codes: 1 = 2X, 2 = 4X, others = none
	input  wire [1:0]  rbin,
	input  wire [1:0]  cbin,
	// Column combine: 1 = sum, 0 = average
	input  wire        csum,
	// Combined pixel
	output wire [11:0] pix
);
	wire [1:0]   rsh;          // Row bin factor as shift
	wire [1:0]   csh;          // Column bin factor as shift
	wire [271:0] acc;          // Running sum chain, 17 words of 16 bits
	wire [15:0]  total;        // Sum of all enabled taps
	wire [15:0]  avg;          // Full average over both directions
	wire [15:0]  rsum;         // Row average, column sum
	assign rsh = (rbin == 2'd1) ? 2'd1 : ((rbin == 2'd2) ? 2'd2 : 2'd0);
	assign csh = (cbin == 2'd1) ? 2'd1 : ((cbin == 2'd2) ? 2'd2 : 2'd0);
	assign acc[15:0] = 16'h0000;
	// Each tap is a same-colour neighbour two pixels away
	genvar k;
	generate
		for (k = 0; k < 16; k = k + 1) begin : g_tap
			localparam [11:0] ROFF = (k / 4) * 2; // Row offset of the tap
			localparam [11:0] COFF = (k % 4) * 2; // Column offset of the tap
			wire [11:0] tr;    // Tap row
			wire [11:0] tc;    // Tap column
			wire        en;    // Tap lies inside the bin window
			wire [11:0] val;   // Test pattern value at the tap
			assign tr  = row + ROFF;
			assign tc  = col + COFF;
			assign en  = ((k / 4) < (1 << rsh)) && ((k % 4) < (1 << csh));
			assign val = {tr[5:0], tc[5:0]};
			assign acc[16*k+31:16*k+16] = acc[16*k+15:16*k] + (en ? {4'h0, val} : 16'h0000);
		end
	endgenerate
	assign total = acc[271:256];
	// Shift sum kept three bits wide so 4X by 4X divides by sixteen
	assign avg   = total >> ({1'b0, rsh} + {1'b0, csh});
	assign rsum  = total >> rsh;
	// Summing saturates at full scale, giving gain near the column factor
	assign pix = csum ? ((rsum > 16'h0FFF) ? 12'hFFF : rsum[11:0]) : avg[11:0];
endmodule // ispr_binner

// File: ispr_capture_model.sv
// Capture logic on the far side of the pixel port
`timescale 1ns/1ps
module ispr_capture_model (
	// Pixel port pins
	input wire        pclk,
	input wire [11:0] dout,
	input wire        fq,
	input wire        lq,
	// Frame statistics
	output reg [15:0] frames,
	output reg [11:0] first_pix,
	output reg [11:0] third_pix,
	output reg [11:0] line_len,
	output reg [11:0] lines
);
	reg [11:0] cnt;  // Pixels so far in the line
	reg [11:0] lcnt; // Lines so far in the frame
	reg        lq_d; // Previous line qualifier
	reg        fq_d; // Previous frame qualifier
	initial begin
		{frames, first_pix, third_pix, line_len, lines, cnt, lcnt, lq_d, fq_d} = 0;
	end
	// Everything is taken on the falling pixel clock
	always @(negedge pclk) begin
		lq_d <= lq;
		fq_d <= fq;
		if (lq && !lq_d) begin
			// Line start; a frame start restarts the line count
			cnt <= 12'h001;
			lcnt <= (fq_d ? lcnt : 12'h000) + 12'h001;
			if (!fq_d)
				first_pix <= dout;
		end else if (lq)
			cnt <= cnt + 12'h001;
		if (lq && lq_d && cnt == 12'h002 && lcnt == 12'h001)
			third_pix <= dout;
		if (!lq && lq_d)
			line_len <= cnt;
		if (!fq && fq_d) begin
			lines <= lcnt;
			frames <= frames + 16'h0001;
		end
	end
endmodule // ispr_capture_model

// File: ispr_defines.vh
// Constants shared by the pixel readout design: offsets, fields, resets, timing
`ifndef ISPR_DEFINES_VH
`define ISPR_DEFINES_VH

// Register byte offsets on the APB port
`define ISPR_OFF_CTRL    12'h000
`define ISPR_OFF_WIDTH   12'h004
`define ISPR_OFF_HEIGHT  12'h008
`define ISPR_OFF_HBLANK  12'h00C
`define ISPR_OFF_VBLANK  12'h010
`define ISPR_OFF_EXPO    12'h014
`define ISPR_OFF_STATUS  12'h018
`define ISPR_OFF_FCOUNT  12'h01C

// Control register field positions (two-bit fields give their low bit)
`define ISPR_CTRL_SNAP   0
`define ISPR_CTRL_BULB   1
`define ISPR_CTRL_CSUM   2
`define ISPR_CTRL_RSKIP  3
`define ISPR_CTRL_CSKIP  5
`define ISPR_CTRL_RBIN   7
`define ISPR_CTRL_CBIN   9
`define ISPR_CTRL_BITS   11

// Status register field positions
`define ISPR_STAT_FRAME  0
`define ISPR_STAT_LINE   1
`define ISPR_STAT_STBY   2
`define ISPR_STAT_STROBE 3
`define ISPR_STAT_ASEL   4
`define ISPR_STAT_ID     8

// Reset values
`define ISPR_RST_CTRL    11'h000
`define ISPR_RST_WIDTH   12'hA20
`define ISPR_RST_HEIGHT  12'h798
`define ISPR_RST_HBLANK  12'h0C8
`define ISPR_RST_VBLANK  12'h019
`define ISPR_RST_EXPO    16'h03E8

// Array position of the first pixel read out
`define ISPR_COL0        12'h010
`define ISPR_ROW0        12'h036

// Two-wire slave addresses chosen by the address-select pin
`define ISPR_ID_HIGH     8'hBA
`define ISPR_ID_LOW      8'h90

// Frame timing: clock rate in Hz and default frame rate in frames per second
`define ISPR_CLK_HZ      100000000
`define ISPR_FRAME_RATE  14

`endif

// File: ispr_readout.v
// Pixel readout core: control pins, frame sequencer, parallel pixel port, APB registers
//
// Functional notes
// - Low reset clears device without clock
// - After reset all registers hold defaults
// - Output disable releases pixel port pins
// - Standby input low holds low-power idle
// - Trigger pulse gives one frame; bulb end
// - Two-wire address BA when select high, 90
// - Each pixel is a 12-bit word, msb 11
// - Frame qualifier high except vertical blanking
// - Line qualifier high only on active pixels
// - Strobe high while whole array exposes
// - First pixel read is column 16, row 54
// - Progressive rows framed by blanking intervals
// - No subsampling gives full field of view
// - Skip 2X drops one pair, 3X two
// - Rows and columns stepped in pairs
// - 2X and 4X binning, rows and columns apart
// - Binning uses every pixel of the view
// - Column bin averages or sums selectably
// - Pixel clock tracks data; qualifiers own pins
// - Default streams full frames at 14 fps; the default window needs about 10.9 million clocks, near 9 fps
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "ispr_defines.vh"
module ispr_readout #(
	parameter [31:0] FRAME_CYCLES = `ISPR_CLK_HZ / `ISPR_FRAME_RATE
) (
	// Clock and reset
	input  wire        MCLK,
	input  wire        RESETN,
	// APB slave
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	// Control pins
	input  wire        OUTPUT_DISABLE,
	input  wire        STANDBY_N,
	input  wire        SNAP_REQ,
	input  wire        BUS_ADDRESS_SELECT,
	// Pixel port
	output reg         PIXEL_SAMPLE_CLOCK,
	output reg  [11:0] DOUT,
	output reg         FRAME_QUAL,
	output reg         LINE_QUAL,
	output reg         EXPO_STROBE,
	output reg         PIX_OUT_EN_N,
	// Two-wire slave address in use
	output reg  [7:0]  BUS_DEVICE_ID
);
	// One-hot sequencer states
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_EXPO = 6'h02;
	localparam [5:0] S_LINE = 6'h04;
	localparam [5:0] S_HBLK = 6'h08;
	localparam [5:0] S_VBLK = 6'h10;
	localparam [5:0] S_STBY = 6'h20;

	reg  [3:0]  sync1_r;       // First synchroniser stage of the four pins
	reg  [3:0]  sync2_r;       // Second synchroniser stage
	reg         snap_d_r;      // Delayed trigger for edge detection
	reg  [`ISPR_CTRL_BITS-1:0] ctrl_r; // Mode and subsampling control
	reg  [11:0] width_r;       // Window width in array columns
	reg  [11:0] height_r;      // Window height in array rows
	reg  [11:0] hblank_r;      // Horizontal blanking in pixel ticks
	reg  [11:0] vblank_r;      // Vertical blanking in pixel ticks
	reg  [15:0] expo_r;        // Snapshot exposure in pixel ticks
	reg  [31:0] fcount_r;      // Completed frame counter
	reg  [5:0]  state_r;       // Sequencer state
	reg  [15:0] cnt_r;         // Blanking and exposure down counter
	reg  [31:0] ftmr_r;        // Frame period timer in clock cycles
	reg         pend_r;        // Trigger pulse awaiting service
	reg  [11:0] coloff_r;      // Column pair base within window
	reg         cpar_r;        // Column within pair
	reg  [11:0] rowoff_r;      // Row pair base within window
	reg         rpar_r;        // Row within pair
	reg         line_end_r;    // Line pixels all emitted
	reg  [31:0] rdata_nxt;     // Read data mux
	reg         rerr_nxt;      // Unmapped address flag
	reg  [3:0]  cs_f;          // Column skip factor
	reg  [3:0]  rs_f;          // Row skip factor
	reg  [3:0]  cb_f;          // Column bin factor
	reg  [3:0]  rb_f;          // Row bin factor
	wire        out_dis_s;     // Synchronised output disable
	wire        stby_s;        // Synchronised standby request
	wire        snap_s;        // Synchronised trigger level
	wire        asel_s;        // Synchronised address select
	wire        snap_rise;     // Trigger rising edge
	wire        snap_mode;     // Snapshot or bulb triggering
	wire        bulb;          // Bulb exposure mode
	wire        tick;          // Pixel clock about to rise
	wire        fdone;         // Frame period elapsed
	wire        start_fr;      // First pixel of a frame this tick
	wire        emit;          // A pixel is presented this tick
	wire        take;          // Pending trigger consumed
	wire [3:0]  cstep;         // Column pair stride in pairs
	wire [3:0]  rstep;         // Row pair stride in pairs
	wire [12:0] cnext;         // Next column pair base
	wire [12:0] rnext;         // Next row pair base
	wire        col_last;      // Current pixel ends the line
	wire        row_last;      // Current row ends the frame
	wire [11:0] pix_row;       // Array row of current pixel
	wire [11:0] pix_col;       // Array column of current pixel
	wire [11:0] bin_pix;       // Pixel value after binning
	wire        wr_en;         // APB write takes effect
	wire        acc_ph;        // APB access phase

	assign out_dis_s = sync2_r[0];
	assign stby_s    = ~sync2_r[1];
	assign snap_s    = sync2_r[2];
	assign asel_s    = sync2_r[3];
	assign snap_rise = snap_s & ~snap_d_r;
	assign bulb      = ctrl_r[`ISPR_CTRL_BULB];
	assign snap_mode = ctrl_r[`ISPR_CTRL_SNAP] | bulb;
	assign tick      = ~PIXEL_SAMPLE_CLOCK & ~stby_s;
	assign fdone     = (ftmr_r == FRAME_CYCLES - 32'd1);

	// Pins from outside pass two flip-flops before any logic reads them
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			sync1_r  <= 4'h2;
			sync2_r  <= 4'h2;
			snap_d_r <= 1'b0;
		end else begin
			sync1_r  <= {BUS_ADDRESS_SELECT, SNAP_REQ, STANDBY_N, OUTPUT_DISABLE};
			sync2_r  <= sync1_r;
			snap_d_r <= sync2_r[2];
		end
	end

	// Decode skip and bin codes into factors; unsupported codes act as one
	always @* begin
		case (ctrl_r[`ISPR_CTRL_CSKIP+1:`ISPR_CTRL_CSKIP])
			2'd1:    cs_f = 4'h2;
			2'd2:    cs_f = 4'h3;
			default: cs_f = 4'h1;
		endcase
		case (ctrl_r[`ISPR_CTRL_RSKIP+1:`ISPR_CTRL_RSKIP])
			2'd1:    rs_f = 4'h2;
			2'd2:    rs_f = 4'h3;
			default: rs_f = 4'h1;
		endcase
		case (ctrl_r[`ISPR_CTRL_CBIN+1:`ISPR_CTRL_CBIN])
			2'd1:    cb_f = 4'h2;
			2'd2:    cb_f = 4'h4;
			default: cb_f = 4'h1;
		endcase
		case (ctrl_r[`ISPR_CTRL_RBIN+1:`ISPR_CTRL_RBIN])
			2'd1:    rb_f = 4'h2;
			2'd2:    rb_f = 4'h4;
			default: rb_f = 4'h1;
		endcase
	end

	// Pairs advance by skip times bin pairs, so colour order is kept
	assign cstep    = cs_f * cb_f;
	assign rstep    = rs_f * rb_f;
	assign cnext    = {1'b0, coloff_r} + {8'h00, cstep, 1'b0};
	assign rnext    = {1'b0, rowoff_r} + {8'h00, rstep, 1'b0};
	assign col_last = cpar_r & (cnext >= {1'b0, width_r});
	assign row_last = rpar_r & (rnext >= {1'b0, height_r});
	assign pix_col  = `ISPR_COL0 + coloff_r + {11'h000, cpar_r};
	assign pix_row  = `ISPR_ROW0 + rowoff_r + {11'h000, rpar_r};

	// Frame starts: timer in streaming, exposure count end in snapshot, trigger fall in bulb
	assign start_fr = tick & (((state_r == S_IDLE) & ~snap_mode & fdone) |
		((state_r == S_EXPO) & (bulb ? ~snap_s : (cnt_r == 16'h0000))));
	assign emit     = start_fr | (tick & (((state_r == S_LINE) & ~line_end_r) |
		((state_r == S_HBLK) & (cnt_r == 16'h0000))));
	assign take     = tick & (state_r == S_IDLE) & snap_mode & pend_r;

	// Pixel value for the current coordinate, binned as configured
	ispr_binner u_binner (
		.row  (pix_row),
		.col  (pix_col),
		.rbin (ctrl_r[`ISPR_CTRL_RBIN+1:`ISPR_CTRL_RBIN]),
		.cbin (ctrl_r[`ISPR_CTRL_CBIN+1:`ISPR_CTRL_CBIN]),
		.csum (ctrl_r[`ISPR_CTRL_CSUM]),
		.pix  (bin_pix)
	);

	// Sequencer: pixel clock, qualifiers, strobe, data and readout position
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			state_r            <= S_IDLE;
			PIXEL_SAMPLE_CLOCK <= 1'b0;
			DOUT               <= 12'h000;
			FRAME_QUAL         <= 1'b0;
			LINE_QUAL          <= 1'b0;
			EXPO_STROBE        <= 1'b0;
			cnt_r              <= 16'h0000;
			ftmr_r             <= 32'h00000000;
			pend_r             <= 1'b0;
			coloff_r           <= 12'h000;
			cpar_r             <= 1'b0;
			rowoff_r           <= 12'h000;
			rpar_r             <= 1'b0;
			line_end_r         <= 1'b0;
			fcount_r           <= 32'h00000000;
		end else begin
			// Pixel clock halts low in standby, data changes as it rises
			PIXEL_SAMPLE_CLOCK <= stby_s ? 1'b0 : ~PIXEL_SAMPLE_CLOCK;
			// Frame period timer saturates until the next frame starts
			if (start_fr) begin
				ftmr_r <= 32'h00000000;
			end else if (!fdone) begin
				ftmr_r <= ftmr_r + 32'd1;
			end
			// A trigger arriving as the pending one is taken is kept;
			// a stale trigger from streaming mode is dropped
			pend_r <= snap_rise | (pend_r & ~take & snap_mode);
			if (stby_s) begin
				state_r     <= S_STBY;
				FRAME_QUAL  <= 1'b0;
				LINE_QUAL   <= 1'b0;
				EXPO_STROBE <= 1'b0;
				line_end_r  <= 1'b0;
				coloff_r    <= 12'h000;
				cpar_r      <= 1'b0;
				rowoff_r    <= 12'h000;
				rpar_r      <= 1'b0;
			end else if (emit) begin
				// Present one pixel with both qualifiers high
				state_r     <= S_LINE;
				DOUT        <= bin_pix;
				FRAME_QUAL  <= 1'b1;
				LINE_QUAL   <= 1'b1;
				EXPO_STROBE <= 1'b0;
				cpar_r      <= ~cpar_r;
				if (cpar_r) begin
					coloff_r <= col_last ? 12'h000 : cnext[11:0];
				end
				line_end_r  <= col_last;
			end else if (tick) begin
				case (state_r)
					S_STBY: begin
						// Leaving standby waits for the next frame slot
						state_r <= S_IDLE;
					end
					S_IDLE: begin
						// Trigger starts a global exposure in snapshot modes
						if (take) begin
							state_r     <= S_EXPO;
							EXPO_STROBE <= 1'b1;
							cnt_r       <= expo_r;
						end
					end
					S_EXPO: begin
						// Timed exposure counts down; bulb waits for trigger fall
						cnt_r <= cnt_r - 16'h0001;
					end
					S_LINE: begin
						// Line finished: blank horizontally or end the frame
						LINE_QUAL  <= 1'b0;
						DOUT       <= 12'h000;
						line_end_r <= 1'b0;
						rpar_r     <= ~rpar_r;
						if (rpar_r) begin
							rowoff_r <= row_last ? 12'h000 : rnext[11:0];
						end
						if (row_last) begin
							state_r    <= S_VBLK;
							FRAME_QUAL <= 1'b0;
							cnt_r      <= {4'h0, vblank_r};
							fcount_r   <= fcount_r + 32'd1;
						end else begin
							state_r <= S_HBLK;
							cnt_r   <= {4'h0, hblank_r};
						end
					end
					S_HBLK: begin
						// Frame qualifier stays high through horizontal blanking
						cnt_r <= cnt_r - 16'h0001;
					end
					S_VBLK: begin
						// Vertical blanking, then wait for the next frame
						if (cnt_r == 16'h0000) begin
							state_r <= S_IDLE;
						end else begin
							cnt_r <= cnt_r - 16'h0001;
						end
					end
					default: begin
						state_r <= S_IDLE;
					end
				endcase
			end
		end
	end

	// Pin drivers are released while output disable is high
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			PIX_OUT_EN_N  <= 1'b1;
			BUS_DEVICE_ID <= `ISPR_ID_LOW;
		end else begin
			PIX_OUT_EN_N  <= out_dis_s;
			BUS_DEVICE_ID <= asel_s ? `ISPR_ID_HIGH : `ISPR_ID_LOW;
		end
	end

	// APB: one wait state, write lands on the edge where PREADY is seen high
	assign acc_ph = PSEL & PENABLE;
	assign wr_en  = acc_ph & PREADY & PWRITE;

	// Read mux and unmapped address detection
	always @* begin
		rdata_nxt = 32'h00000000;
		rerr_nxt  = 1'b0;
		case (PADDR)
			`ISPR_OFF_CTRL:   rdata_nxt = {21'h00000, ctrl_r};
			`ISPR_OFF_WIDTH:  rdata_nxt = {20'h00000, width_r};
			`ISPR_OFF_HEIGHT: rdata_nxt = {20'h00000, height_r};
			`ISPR_OFF_HBLANK: rdata_nxt = {20'h00000, hblank_r};
			`ISPR_OFF_VBLANK: rdata_nxt = {20'h00000, vblank_r};
			`ISPR_OFF_EXPO:   rdata_nxt = {16'h0000, expo_r};
			`ISPR_OFF_STATUS: begin
				rdata_nxt[`ISPR_STAT_FRAME]  = FRAME_QUAL;
				rdata_nxt[`ISPR_STAT_LINE]   = LINE_QUAL;
				rdata_nxt[`ISPR_STAT_STBY]   = (state_r == S_STBY);
				rdata_nxt[`ISPR_STAT_STROBE] = EXPO_STROBE;
				rdata_nxt[`ISPR_STAT_ASEL]   = asel_s;
				rdata_nxt[`ISPR_STAT_ID+7:`ISPR_STAT_ID] = BUS_DEVICE_ID;
			end
			`ISPR_OFF_FCOUNT: rdata_nxt = fcount_r;
			default:          rerr_nxt  = 1'b1;
		endcase
	end

	// APB handshake and registers, all back to defaults on reset
	always @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			PREADY   <= 1'b0;
			PRDATA   <= 32'h00000000;
			PSLVERR  <= 1'b0;
			ctrl_r   <= `ISPR_RST_CTRL;
			width_r  <= `ISPR_RST_WIDTH;
			height_r <= `ISPR_RST_HEIGHT;
			hblank_r <= `ISPR_RST_HBLANK;
			vblank_r <= `ISPR_RST_VBLANK;
			expo_r   <= `ISPR_RST_EXPO;
		end else begin
			PREADY  <= acc_ph & ~PREADY;
			PRDATA  <= (acc_ph & ~PREADY & ~PWRITE) ? rdata_nxt : 32'h00000000;
			PSLVERR <= acc_ph & ~PREADY & rerr_nxt;
			if (wr_en) begin
				// Only mapped writable registers take the write data
				case (PADDR)
					`ISPR_OFF_CTRL:   ctrl_r   <= PWDATA[`ISPR_CTRL_BITS-1:0];
					`ISPR_OFF_WIDTH:  width_r  <= PWDATA[11:0];
					`ISPR_OFF_HEIGHT: height_r <= PWDATA[11:0];
					`ISPR_OFF_HBLANK: hblank_r <= PWDATA[11:0];
					`ISPR_OFF_VBLANK: vblank_r <= PWDATA[11:0];
					`ISPR_OFF_EXPO:   expo_r   <= PWDATA[15:0];
					default: begin
						ctrl_r <= ctrl_r;
					end
				endcase
			end
		end
	end
endmodule // ispr_readout

// File: tb_top.sv
// Self-checking bench for the pixel readout block
`timescale 1ns/1ps
module tb_top;
	localparam [31:0] FRAME_N = 32'h7D0; // Shortened frame period
	// Design inputs
	reg         mclk, resetn, psel, penable, pwrite, od, stby_n, snap, asel;
	reg  [11:0] paddr;
	reg  [31:0] pwdata;
	// Design outputs
	wire [31:0] prdata;
	wire        pready, pslverr, pclk, fq, lq, strobe, en_n;
	wire [11:0] dout;
	wire [7:0]  dev_id;
	// Pin levels at the capture side
	wire        pclk_pin, fq_pin, lq_pin;
	wire [11:0] dout_pin;
	// Capture statistics
	wire [15:0] frames;
	wire [11:0] first_pix, third_pix, line_len, lines;
	// Bookkeeping
	integer     failures, check_count;
	reg  [31:0] rd;
	reg         err;

	always #5 mclk = ~mclk;

	// Released pins fall to board pulldowns
	assign pclk_pin = en_n ? 1'b0 : pclk;
	assign fq_pin   = en_n ? 1'b0 : fq;
	assign lq_pin   = en_n ? 1'b0 : lq;
	assign dout_pin = en_n ? 12'h000 : dout;

	ispr_readout #(.FRAME_CYCLES(FRAME_N)) dut (
		.MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.OUTPUT_DISABLE(od), .STANDBY_N(stby_n), .SNAP_REQ(snap), .BUS_ADDRESS_SELECT(asel),
		.PIXEL_SAMPLE_CLOCK(pclk), .DOUT(dout), .FRAME_QUAL(fq), .LINE_QUAL(lq),
		.EXPO_STROBE(strobe), .PIX_OUT_EN_N(en_n), .BUS_DEVICE_ID(dev_id)
	);
	ispr_capture_model cap (
		.pclk(pclk_pin), .dout(dout_pin), .fq(fq_pin), .lq(lq_pin), .frames(frames),
		.first_pix(first_pix), .third_pix(third_pix), .line_len(line_len), .lines(lines)
	);

	// Verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Compare one value
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count = check_count + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer, held until PREADY is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		integer n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n = n + 1;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures = failures + 1;
			report_and_stop;
		end
		@(posedge mclk);
	endtask
	// Wait for more completed frames, bounded
	task automatic wait_frames(input integer n);
		integer i;
		integer f0;
		f0 = frames;
		for (i = 0; i < 6000 * n && frames < f0 + n; i = i + 1)
			@(posedge mclk);
		if (frames < f0 + n) begin
			failures = failures + 1;
			report_and_stop;
		end
	endtask
	// Register defaults and an unmapped access
	task automatic t_defaults;
		reg [31:0] exp [0:5];
		integer i;
		exp = '{32'h0, 32'hA20, 32'h798, 32'h0C8, 32'h019, 32'h3E8};
		for (i = 0; i < 6; i = i + 1) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			check("reset value", exp[i], rd);
		end
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped error", 32'h1, {31'h0, err});
	endtask
	// Readout order under eight modes: none, column skip 2X and 3X, row skip 2X, column bin 2X, 4X and sum, row bin 2X
	task automatic t_modes;
		reg [59:0] tab [0:7];
		integer i;
		tab = '{{12'h000, 12'h018, 12'h004, 12'hD90, 12'hD92},
			{12'h020, 12'h00C, 12'h004, 12'hD90, 12'hD94},
			{12'h040, 12'h008, 12'h004, 12'hD90, 12'hD96},
			{12'h008, 12'h018, 12'h002, 12'hD90, 12'hD92},
			{12'h200, 12'h00C, 12'h004, 12'hD91, 12'hD95},
			{12'h204, 12'h00C, 12'h004, 12'hFFF, 12'hFFF},
			{12'h080, 12'h018, 12'h002, 12'hDD0, 12'hDD2},
			{12'h400, 12'h006, 12'h004, 12'hD93, 12'hD9B}};
		apb(1'b1, 12'h004, 32'h18);
		apb(1'b1, 12'h008, 32'h4);
		apb(1'b1, 12'h00C, 32'h3);
		apb(1'b1, 12'h010, 32'h2);
		for (i = 0; i < 8; i = i + 1) begin
			apb(1'b1, 12'h000, {20'h0, tab[i][59:48]});
			wait_frames(2);
			check("line length", tab[i][47:36], line_len);
			check("lines", tab[i][35:24], lines);
			check("first pixel", tab[i][23:12], first_pix);
			check("third pixel", tab[i][11:0], third_pix);
		end
		apb(1'b1, 12'h000, 32'h0);
	endtask
	// Address select, output disable and standby pins
	task automatic t_pins;
		asel <= 1'b1;
		od <= 1'b1;
		repeat (6) @(posedge mclk);
		check("id high", 32'hBA, dev_id);
		check("released", 32'h1, en_n);
		asel <= 1'b0;
		od <= 1'b0;
		stby_n <= 1'b0;
		repeat (6) @(posedge mclk);
		check("id low", 32'h90, dev_id);
		check("driven", 32'h0, en_n);
		check("standby frame", 32'h0, {31'h0, fq});
		apb(1'b0, 12'h018, 32'h0);
		check("standby status", 32'h9004, rd);
		stby_n <= 1'b1;
		wait_frames(2);
	endtask
	// Snapshot: strobe length and one frame per trigger
	task automatic t_snap;
		integer n;
		integer f0;
		apb(1'b1, 12'h014, 32'h5);
		apb(1'b1, 12'h000, 32'h1);
		repeat (600) @(posedge mclk);
		f0 = frames;
		snap <= 1'b1;
		repeat (4) @(posedge mclk);
		snap <= 1'b0;
		n = 0;
		while (strobe !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n = n + 1;
		end
		n = 0;
		while (strobe === 1'b1 && n < 100) begin
			@(posedge mclk);
			n = n + 1;
		end
		check("strobe cycles", 32'hC, n);
		repeat (5000) @(posedge mclk);
		check("snapshot frames", f0 + 1, frames);
		// Bulb: strobe outlasts the timed exposure until the trigger falls
		apb(1'b1, 12'h000, 32'h2);
		f0 = frames;
		snap <= 1'b1;
		repeat (40) @(posedge mclk);
		check("bulb strobe", 32'h1, strobe);
		snap <= 1'b0;
		repeat (2000) @(posedge mclk);
		check("bulb frames", f0 + 1, frames);
	endtask
	// Asynchronous reset mid-run restores defaults
	task automatic t_reset;
		apb(1'b1, 12'h004, 32'h8);
		resetn <= 1'b0;
		#1 check("reset enable", 32'h1, en_n);
		@(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		apb(1'b0, 12'h004, 32'h0);
		check("width default", 32'hA20, rd);
	endtask

	initial begin
		{mclk, psel, penable, pwrite, od, snap, asel} = 0;
		stby_n = 1'b1;
		resetn = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		failures = 0;
		check_count = 0;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		t_defaults;
		$display("defaults done, mismatches %0d", failures);
		t_modes;
		$display("modes done, mismatches %0d", failures);
		t_pins;
		$display("pins done, mismatches %0d", failures);
		t_snap;
		$display("snapshot done, mismatches %0d", failures);
		t_reset;
		$display("reset done, mismatches %0d", failures);
		report_and_stop;
	end
	// Watchdog
	initial begin
		repeat (100000) @(posedge mclk);
		failures = failures + 1;
		report_and_stop;
	end
endmodule // tb_top
